// File: include/spm_defines.svh
// constants for the spi slave and power mode controller
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH

// core clock
`define CLK_PERIOD_NS       10

// frame layout
`define FRAME_BITS          16
`define CMD_CODE_MSB        15
`define CMD_CODE_LSB        12

// control command data fields
`define CTRL_PWR_HOLD_BIT   11
`define CTRL_PROTECTED_SENSOR_SUPPLY_BIT      10
`define CTRL_OUT_MSB        7
`define CTRL_OUT_LSB        0

// config command data fields
`define CFG_SDD_BIT         0

// driver index of relay two within the driver vector
`define RELAY_TWO_IDX       1

// reset values
`define OUT_REQ_RESET       8'h00
`define PIN_SYNC_RESET      15'h4000

// timing
`define POR_DELAY_NS        5000
`define UV_FILTER_NS        1000
`define POR_DELAY_CYC       ((`POR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UV_FILTER_CYC       ((`UV_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: include/spm_pkg.sv
// types shared by the spi slave and power mode controller
package spm_pkg;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_APPLY = 3'b100
	} frame_state_e;

	typedef enum logic [3:0] {
		CMD_NOP  = 4'h0,
		CMD_CTRL = 4'h1,
		CMD_CFG  = 4'h2
	} cmd_code_e;

	typedef struct packed {
		logic       cs_n;
		logic       sclk;
		logic       sdi;
		logic       key;
		logic       ov;
		logic       above_por;
		logic       below_uv;
		logic [7:0] fault;
	} pin_in_s;

	typedef struct packed {
		logic       spi_error;
		logic       key_on;
		logic       overvoltage;
		logic [4:0] zero;
		logic [7:0] fault;
	} status_word_s;

endpackage

// File: logic/pin_sync.sv
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int             W   = 1,
	parameter logic [W-1:0]   RST = '0
) (
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= RST;
			q      <= RST;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// File: logic/por_sequencer.sv
// power-on and undervoltage reset sequencer for the host reset line
`timescale 1ns/1ps
`include "spm_defines.svh"
module por_sequencer #(
	parameter int unsigned POR_CYC = `POR_DELAY_CYC,
	parameter int unsigned UV_CYC  = `UV_FILTER_CYC
) (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic restart,
	input  wire logic above_por,
	input  wire logic below_uv,
	output logic      reset_n
);
	localparam int CW = 16;

	logic [CW-1:0] por_cnt_r;
	logic [CW-1:0] uv_cnt_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			por_cnt_r <= '0;
		end else if (restart || reset_n || !above_por) begin
			por_cnt_r <= '0;
		end else begin
			por_cnt_r <= por_cnt_r + CW'(1); // RQ12
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			uv_cnt_r <= '0;
		end else if (!reset_n || !below_uv) begin
			uv_cnt_r <= '0;
		end else if (uv_cnt_r != CW'(UV_CYC)) begin
			uv_cnt_r <= uv_cnt_r + CW'(1); // RQ13
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reset_n <= 1'b0;
		end else if (restart || uv_cnt_r == CW'(UV_CYC)) begin
			reset_n <= 1'b0; // RQ13 RQ18
		end else if (!reset_n && above_por && por_cnt_r == CW'(POR_CYC - 1)) begin
			reset_n <= 1'b1; // RQ12
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	property p_por_release;
		$rose(reset_n) |-> $past(por_cnt_r) == CW'(POR_CYC - 1) && $past(above_por);
	endproperty
	a_por_release: assert property (p_por_release) // RQ12
		else $error("reset released before the power-on delay ran out");

	property p_por_hold;
		!reset_n && por_cnt_r < CW'(POR_CYC - 1) |=> !reset_n;
	endproperty
	a_por_hold: assert property (p_por_hold) // RQ12
		else $error("reset released early");

	property p_uv_reset;
		reset_n && below_uv && uv_cnt_r == CW'(UV_CYC - 1) |=> ##1 !reset_n;
	endproperty
	a_uv_reset: assert property (p_uv_reset) // RQ13
		else $error("undervoltage past filter did not assert reset");

	property p_restart;
		restart |=> !reset_n ##1 !reset_n;
	endproperty
	a_restart: assert property (p_restart) // RQ18
		else $error("wake did not start a power-on reset");
endmodule

// File: logic/spi_power_ctrl.sv
// spi slave front end and power mode control
// Overview of operation
// (RQ1) sample serial input into receive register on each serial clock rise in frame
// (RQ2) move serial output to next status bit on each serial clock fall
// (RQ3) with chip select high ignore clock and data, output high impedance
// (RQ4) frames must hold exactly 16 clocks, otherwise set the spi error flag
// (RQ5) an invalid command code also sets the spi error flag
// (RQ6) chip select fall enables output driver and loads the status word
// (RQ7) chip select rise releases output and applies the received command
// (RQ8) host moves chip select only while serial clock is low
// (RQ9) command and status words travel most significant bit first, together
// (RQ10) status reports a healthy driver as zero and a faulty one as one
// (RQ11) battery overvoltage switches off all outputs and all regulators
// (RQ12) reset output stays low a fixed delay after supply passes power-on level
// (RQ13) supply under undervoltage level past its filter drives reset low
// (RQ14) protected sensor supply follows its enable bit written over spi
// (RQ15) key switch low and power hold clear means sleep mode
// (RQ16) key switch fall with power hold set turns off outputs only, except relay two
// (RQ17) clearing power hold while key switch is low puts the device to sleep
// (RQ18) key switch rise wakes, enables pre-regulator and starts a power-on reset
// (RQ19) key switch level is a bit of the status word
// (RQ20) only the power hold bit governs supply shutdown
// (RQ21) a frame flagged as an spi error is not applied
`timescale 1ns/1ps
`include "spm_defines.svh"
module spi_power_ctrl #(
	parameter int unsigned POR_CYC = `POR_DELAY_CYC,
	parameter int unsigned UV_CYC  = `UV_FILTER_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        chip_select_n,
	input  wire logic        sclk_in,
	input  wire logic        sdi_in,
	output logic             sdo,
	output logic             sdo_oe,
	input  wire logic        key_switch_in,
	input  wire logic        battery_supply_ov,
	input  wire logic        vcc_above_por,
	input  wire logic        vcc_below_uv,
	input  wire logic [7:0]  driver_fault,
	output logic      [7:0]  driver_enable,
	output logic             pre_regulator_enable,
	output logic             regulators_enable,
	output logic             protected_sensor_supply,
	output logic             sleep_mode,
	output logic             spi_error,
	output logic             host_reset_n
);
	import spm_pkg::*;

	function automatic logic cmd_valid(input logic [3:0] code);
		cmd_valid = (code == CMD_NOP) || (code == CMD_CTRL) || (code == CMD_CFG);
	endfunction

	spm_pkg::pin_in_s      pins_raw;
	spm_pkg::pin_in_s      pins_s;
	spm_pkg::status_word_s status_now;
	frame_state_e          state_r;
	logic                  cs_d_r;
	logic                  sclk_d_r;
	logic [15:0]           rx_r;
	logic [15:0]           tx_r;
	logic [4:0]            bit_cnt_r;
	logic                  spi_error_r;
	logic                  power_hold_enable_r;
	logic                  protected_sensor_supply_enable_r;
	logic                  relay_two_shutdown_disable_r;
	logic [7:0]            out_req_r;
	logic                  key_d_r;
	logic                  cs_fall;
	logic                  cs_rise;
	logic                  sclk_rise;
	logic                  sclk_fall;
	logic                  frame_ok;
	logic                  sleep_now;
	logic                  regs_on;
	logic [7:0]            keep_mask;
	logic                  key_rise;
	logic [3:0]            rx_code;

	assign pins_raw = '{cs_n: chip_select_n, sclk: sclk_in, sdi: sdi_in,
		key: key_switch_in, ov: battery_supply_ov, above_por: vcc_above_por,
		below_uv: vcc_below_uv, fault: driver_fault};

	pin_sync #(
		.W   ($bits(pin_in_s)),
		.RST (`PIN_SYNC_RESET)
	) u_pin_sync (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.d       (pins_raw),
		.q       (pins_s)
	);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cs_d_r   <= 1'b1;
			sclk_d_r <= 1'b0;
			key_d_r  <= 1'b0;
		end else begin
			cs_d_r   <= pins_s.cs_n;
			sclk_d_r <= pins_s.sclk;
			key_d_r  <= pins_s.key;
		end
	end

	assign cs_fall   = cs_d_r && !pins_s.cs_n;
	assign cs_rise   = !cs_d_r && pins_s.cs_n;
	assign sclk_rise = !sclk_d_r && pins_s.sclk;
	assign sclk_fall = sclk_d_r && !pins_s.sclk;
	assign key_rise  = !key_d_r && pins_s.key;
	assign rx_code   = rx_r[`CMD_CODE_MSB:`CMD_CODE_LSB];
	assign frame_ok  = (bit_cnt_r == 5'(`FRAME_BITS)) && cmd_valid(rx_code); // RQ4 RQ5

	// status word: faults are one, healthy drivers zero
	assign status_now = '{spi_error: spi_error_r, key_on: pins_s.key, // RQ19
		overvoltage: pins_s.ov, zero: 5'h00, fault: pins_s.fault}; // RQ10

	// frame sequencing; the host keeps the clock low around chip select edges
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (cs_fall) begin
						state_r <= ST_SHIFT; // RQ8
					end
				end
				ST_SHIFT: begin
					if (cs_rise) begin
						state_r <= ST_APPLY;
					end
				end
				ST_APPLY: begin
					state_r <= ST_IDLE;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// receive side and clock count, only inside a frame
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_r      <= 16'h0000;
			bit_cnt_r <= 5'h00;
		end else if (state_r == ST_IDLE && cs_fall) begin
			bit_cnt_r <= 5'h00;
		end else if (state_r == ST_SHIFT && sclk_rise) begin
			rx_r <= {rx_r[14:0], pins_s.sdi}; // RQ1 RQ9
			if (bit_cnt_r != 5'h1F) begin
				bit_cnt_r <= bit_cnt_r + 5'h01; // RQ4
			end
		end
	end

	// transmit side and output driver
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_r   <= 16'h0000;
			sdo    <= 1'b0;
			sdo_oe <= 1'b0;
		end else if (state_r == ST_IDLE && cs_fall) begin
			tx_r   <= status_now; // RQ6
			sdo    <= status_now[15]; // RQ9
			sdo_oe <= 1'b1; // RQ6
		end else if (state_r == ST_SHIFT && cs_rise) begin
			sdo_oe <= 1'b0; // RQ7
		end else if (state_r == ST_SHIFT && sclk_fall) begin
			tx_r <= {tx_r[14:0], 1'b0};
			sdo  <= tx_r[14]; // RQ2
		end else if (state_r != ST_SHIFT) begin
			sdo_oe <= 1'b0; // RQ3
		end
	end

	// error flag: set on a bad frame, cleared once loaded into a status word
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			spi_error_r <= 1'b0;
		end else if (state_r == ST_APPLY && !frame_ok) begin
			spi_error_r <= 1'b1; // RQ4 RQ5
		end else if (state_r == ST_IDLE && cs_fall) begin
			spi_error_r <= 1'b0;
		end
	end

	// command apply at the end of a clean frame
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			power_hold_enable_r          <= 1'b0;
			protected_sensor_supply_enable_r               <= 1'b0;
			relay_two_shutdown_disable_r <= 1'b0;
			out_req_r                    <= `OUT_REQ_RESET;
		end else if (state_r == ST_APPLY && frame_ok) begin // RQ7 RQ21
			if (rx_code == CMD_CTRL) begin
				power_hold_enable_r <= rx_r[`CTRL_PWR_HOLD_BIT]; // RQ20
				protected_sensor_supply_enable_r      <= rx_r[`CTRL_PROTECTED_SENSOR_SUPPLY_BIT]; // RQ14
				out_req_r           <= rx_r[`CTRL_OUT_MSB:`CTRL_OUT_LSB];
			end else if (rx_code == CMD_CFG) begin
				relay_two_shutdown_disable_r <= rx_r[`CFG_SDD_BIT];
			end
		end
	end

	assign sleep_now = !pins_s.key && !power_hold_enable_r; // RQ15 RQ17 RQ20
	assign regs_on   = !sleep_now && !pins_s.ov; // RQ11 RQ18
	assign keep_mask = (relay_two_shutdown_disable_r && power_hold_enable_r)
		? 8'(1 << `RELAY_TWO_IDX) : 8'h00;

	// power mode outputs
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sleep_mode              <= 1'b0;
			pre_regulator_enable    <= 1'b0;
			regulators_enable       <= 1'b0;
			protected_sensor_supply <= 1'b0;
			driver_enable           <= 8'h00;
			spi_error               <= 1'b0;
		end else begin
			sleep_mode              <= sleep_now; // RQ15 RQ17
			pre_regulator_enable    <= regs_on; // RQ18
			regulators_enable       <= regs_on; // RQ11
			protected_sensor_supply <= regs_on && protected_sensor_supply_enable_r; // RQ14
			spi_error               <= spi_error_r;
			if (!regs_on) begin
				driver_enable <= 8'h00; // RQ11
			end else if (pins_s.key) begin
				driver_enable <= out_req_r;
			end else begin
				driver_enable <= out_req_r & keep_mask; // RQ16
			end
		end
	end

	por_sequencer #(
		.POR_CYC (POR_CYC),
		.UV_CYC  (UV_CYC)
	) u_por (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.restart   (key_rise || sleep_now),
		.above_por (pins_s.above_por),
		.below_uv  (pins_s.below_uv),
		.reset_n   (host_reset_n)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	property p_sample_in;
		state_r == ST_SHIFT && sclk_rise && !cs_rise |=> rx_r[0] == $past(pins_s.sdi);
	endproperty
	a_sample_in: assert property (p_sample_in) // RQ1
		else $error("serial input not sampled on clock rise");

	property p_shift_out;
		state_r == ST_SHIFT && sclk_fall && !cs_rise |=> sdo == $past(tx_r[14]) && sdo_oe;
	endproperty
	a_shift_out: assert property (p_shift_out) // RQ2
		else $error("serial output did not advance on clock fall");

	property p_idle_hiz;
		state_r == ST_IDLE && !cs_fall |=> !sdo_oe && $stable(rx_r);
	endproperty
	a_idle_hiz: assert property (p_idle_hiz) // RQ3
		else $error("activity outside a frame");

	property p_count_error;
		state_r == ST_SHIFT && cs_rise && bit_cnt_r != 5'h10 |=> ##1 spi_error_r;
	endproperty
	a_count_error: assert property (p_count_error) // RQ4
		else $error("wrong clock count not flagged");

	property p_bad_cmd;
		state_r == ST_APPLY && !cmd_valid(rx_code) |=> spi_error_r;
	endproperty
	a_bad_cmd: assert property (p_bad_cmd) // RQ5
		else $error("invalid command not flagged");

	property p_load_status;
		state_r == ST_IDLE && cs_fall |=> sdo_oe && sdo == $past(status_now[15])
			&& tx_r == $past(status_now);
	endproperty
	a_load_status: assert property (p_load_status) // RQ6
		else $error("status word not loaded on select fall");

	property p_end_frame;
		state_r == ST_SHIFT && cs_rise |=> !sdo_oe && state_r == ST_APPLY;
	endproperty
	a_end_frame: assert property (p_end_frame) // RQ7
		else $error("output not released on select rise");

	property p_no_apply;
		state_r == ST_APPLY && !frame_ok |=> $stable(out_req_r) && $stable(power_hold_enable_r)
			&& $stable(protected_sensor_supply_enable_r) && $stable(relay_two_shutdown_disable_r);
	endproperty
	a_no_apply: assert property (p_no_apply) // RQ21
		else $error("errored frame changed control state");

	property p_overvoltage;
		pins_s.ov |=> driver_enable == 8'h00 && !regulators_enable && !pre_regulator_enable
			&& !protected_sensor_supply;
	endproperty
	a_overvoltage: assert property (p_overvoltage) // RQ11
		else $error("overvoltage left something on");

	property p_sleep;
		!pins_s.key && !power_hold_enable_r |=> sleep_mode && driver_enable == 8'h00;
	endproperty
	a_sleep: assert property (p_sleep) // RQ15
		else $error("sleep mode not entered");

	property p_key_off_hold;
		!pins_s.key && power_hold_enable_r && !pins_s.ov |=> !sleep_mode
			&& driver_enable == $past(out_req_r & keep_mask);
	endproperty
	a_key_off_hold: assert property (p_key_off_hold) // RQ16
		else $error("key off with power hold handled wrongly");
endmodule

// File: verif/spi_host_model.sv
// host microcontroller model driving the spi link as master, mode 0, msb first
`timescale 1ns/1ps
module spi_host_model #(
	parameter int HALF = 8
) (
	input  wire logic ref_clk,
	input  wire logic sdo,
	input  wire logic sdo_oe,
	output logic      chip_select_n,
	output logic      sclk_in,
	output logic      sdi_in,
	output logic      oe_seen
);
	initial begin
		chip_select_n = 1'b1;
		sclk_in = 1'b0;
		sdi_in = 1'b0;
		oe_seen = 1'b0;
	end

	// also notes whether the device drove its serial output during the wait
	task automatic wait_cyc(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			oe_seen = oe_seen | sdo_oe;
		end
	endtask

	// sel low keeps chip select high while the clock still toggles
	task automatic xfer(input logic [15:0] tx, input int nclk, input logic sel,
		output logic [15:0] rx);
		logic [31:0] sh;
		sh = {tx, 16'h0000};
		rx = 16'h0000;
		oe_seen = 1'b0;
		@(posedge ref_clk);
		chip_select_n <= ~sel;
		wait_cyc(12);
		for (int i = 0; i < nclk; i++) begin
			sdi_in <= sh[31];
			sh = sh << 1;
			wait_cyc(HALF);
			sclk_in <= 1'b1;
			// a released output reads as the inverse of its last level
			rx = {rx[14:0], sdo_oe ? sdo : ~sdo};
			wait_cyc(HALF);
			sclk_in <= 1'b0;
		end
		wait_cyc(HALF);
		chip_select_n <= 1'b1;
		sdi_in <= ~sdi_in;
		wait_cyc(12);
	endtask
endmodule

// File: verif/spi_power_ctrl_bench.sv
// self-checking bench for the spi slave and power mode controller
`timescale 1ns/1ps
module spi_power_ctrl_bench;
	localparam int unsigned POR = 20;
	localparam int unsigned UV  = 5;

	logic        ref_clk;
	logic        nrst;
	logic        key_switch_in;
	logic        battery_supply_ov;
	logic        vcc_above_por;
	logic        vcc_below_uv;
	logic [7:0]  driver_fault;
	logic        chip_select_n;
	logic        sclk_in;
	logic        sdi_in;
	logic        sdo;
	logic        sdo_oe;
	logic        oe_seen;
	logic [7:0]  driver_enable;
	logic        pre_regulator_enable;
	logic        regulators_enable;
	logic        protected_sensor_supply;
	logic        sleep_mode;
	logic        spi_error;
	logic        host_reset_n;
	logic [15:0] rx;
	int          fails;
	int          checks_done;

	spi_power_ctrl #(.POR_CYC(POR), .UV_CYC(UV)) u_spi_power_ctrl (
		.ref_clk, .nrst, .chip_select_n, .sclk_in, .sdi_in, .sdo, .sdo_oe,
		.key_switch_in, .battery_supply_ov, .vcc_above_por, .vcc_below_uv,
		.driver_fault, .driver_enable, .pre_regulator_enable, .regulators_enable,
		.protected_sensor_supply, .sleep_mode, .spi_error, .host_reset_n
	);

	spi_host_model u_spi_host_model (
		.ref_clk, .sdo, .sdo_oe, .chip_select_n, .sclk_in, .sdi_in, .oe_seen
	);

	always #5 ref_clk = ~ref_clk;

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic t_power_up;
		@(posedge ref_clk);
		key_switch_in <= 1'b1;
		vcc_above_por <= 1'b1;
		wait_cyc(10);
		check("sleep", sleep_mode, 1'b0);
		check("prereg", pre_regulator_enable, 1'b1);
		check("rst_held", host_reset_n, 1'b0);
		wait_cyc(POR + 10);
		check("rst_free", host_reset_n, 1'b1);
	endtask

	task automatic t_ignore;
		u_spi_host_model.xfer(16'h1C03, 16, 1'b0, rx);
		check("oe_idle", oe_seen, 1'b0);
		check("drv_idle", driver_enable, 8'h00);
		check("err_idle", spi_error, 1'b0);
	endtask

	task automatic t_control;
		u_spi_host_model.xfer(16'h1C03, 16, 1'b1, rx);
		check("status", rx, 16'h40A5);
		check("oe_frame", oe_seen, 1'b1);
		wait_cyc(10);
		check("oe_after", sdo_oe, 1'b0);
		check("drv", driver_enable, 8'h03);
		check("prot", protected_sensor_supply, 1'b1);
	endtask

	task automatic t_errors;
		logic [15:0] word [3];
		int          nclk [3];
		word = '{16'h1000, 16'h1000, 16'h3000};
		nclk = '{15, 17, 16};
		for (int i = 0; i < 3; i++) begin
			u_spi_host_model.xfer(word[i], nclk[i], 1'b1, rx);
			wait_cyc(10);
			check("err_set", spi_error, 1'b1);
			check("not_applied", driver_enable, 8'h03);
			u_spi_host_model.xfer(16'h0000, 16, 1'b1, rx);
			check("err_status", rx, 16'hC0A5);
			wait_cyc(10);
			check("err_clear", spi_error, 1'b0);
		end
	endtask

	task automatic t_key_off;
		u_spi_host_model.xfer(16'h2001, 16, 1'b1, rx);
		@(posedge ref_clk);
		key_switch_in <= 1'b0;
		wait_cyc(10);
		check("relay_kept", driver_enable, 8'h02);
		check("awake", sleep_mode, 1'b0);
		check("regs_kept", regulators_enable, 1'b1);
		u_spi_host_model.xfer(16'h1003, 16, 1'b1, rx);
		check("key_bit", rx, 16'h00A5);
		wait_cyc(10);
		check("asleep", sleep_mode, 1'b1);
		check("regs_off", regulators_enable, 1'b0);
		check("drv_sleep", driver_enable, 8'h00);
		check("rst_sleep", host_reset_n, 1'b0);
	endtask

	task automatic t_wake;
		@(posedge ref_clk);
		key_switch_in <= 1'b1;
		wait_cyc(10);
		check("wake", sleep_mode, 1'b0);
		check("wake_pre", pre_regulator_enable, 1'b1);
		check("wake_rst", host_reset_n, 1'b0);
		wait_cyc(POR + 10);
		check("wake_rel", host_reset_n, 1'b1);
		check("wake_drv", driver_enable, 8'h03);
	endtask

	task automatic t_undervoltage;
		@(posedge ref_clk);
		vcc_below_uv <= 1'b1;
		wait_cyc(2);
		vcc_below_uv <= 1'b0;
		wait_cyc(10);
		check("uv_glitch", host_reset_n, 1'b1);
		vcc_below_uv <= 1'b1;
		vcc_above_por <= 1'b0;
		wait_cyc(UV + 10);
		check("uv_low", host_reset_n, 1'b0);
		vcc_below_uv <= 1'b0;
		wait_cyc(POR + 10);
		check("uv_hold", host_reset_n, 1'b0);
		vcc_above_por <= 1'b1;
		wait_cyc(POR + 10);
		check("uv_rel", host_reset_n, 1'b1);
	endtask

	task automatic t_overvoltage;
		@(posedge ref_clk);
		battery_supply_ov <= 1'b1;
		wait_cyc(10);
		check("ov_drv", driver_enable, 8'h00);
		check("ov_regs", regulators_enable, 1'b0);
		u_spi_host_model.xfer(16'h0000, 16, 1'b1, rx);
		check("ov_status", rx, 16'h60A5);
		battery_supply_ov <= 1'b0;
		wait_cyc(10);
		check("ov_back", driver_enable, 8'h03);
	endtask

	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		key_switch_in = 1'b0;
		battery_supply_ov = 1'b0;
		vcc_above_por = 1'b0;
		vcc_below_uv = 1'b0;
		driver_fault = 8'hA5;
		fails = 0;
		checks_done = 0;
		wait_cyc(10);
		check("rst_oe", sdo_oe, 1'b0);
		check("rst_drv", driver_enable, 8'h00);
		nrst <= 1'b1;
		wait_cyc(6);
		t_power_up();
		t_ignore();
		t_control();
		t_errors();
		t_key_off();
		t_wake();
		t_undervoltage();
		t_overvoltage();
		conclude();
	end

	initial begin
		wait_cyc(40000);
		fails++;
		conclude();
	end
endmodule
